// File: verilog/vtr_pkg.sv
/*
  vtr_pkg: constants for the vlan table read-back block of a three-port
  switch engine: register indices, field positions, reset values, codes.
  Assumes an apb slave with 32-bit data; byte address is four times index.
*/
// Functional notes
// R1 - read-only 32-bit data register returns vlan or default vid table contents.
// R2 - default vid table read: vid in bits 11:0, priority 14:12, rest zero.
// R3 - untagged or null-vid frames take the ingress port default vid.
// R4 - with global vlan disable set, every frame takes the port default vid.
// R5 - default priority used when no other priority source chose one.
// R6 - after reset each port default vid is 1 and priority 0.
// R7 - software should not program default vid 0 or fff.
// R8 - vlan entry bit 17 is port 2 membership: admit ingress, join egress domain.
// R9 - non-member port drops matching frames unless admit-non-member set; no egress.
// R10 - bit 16 untags port 2 egress, only when port 2 is hybrid.
// R11 - bit 15 is port 1 membership, same behaviour as port 2.
// R12 - bit 14 port 1 untag, bit 13 port 0 member, bit 12 port 0 untag.
// R13 - entry bits 11:0 hold vid; vid 0 disables the entry.
// R14 - pending status set during a table command, cleared on completion.
// R15 - data register holds last completed read; reading has no side effect.
package vtr_pkg;
  // register indices; byte address is index times four
  localparam logic [15:0] IDX_CMD = 16'h180b;
  localparam logic [15:0] IDX_WR_DATA = 16'h180d;
  localparam logic [15:0] IDX_RD_DATA = 16'h180e;
  localparam logic [15:0] IDX_CMD_STATE = 16'h1810;
  localparam logic [15:0] IDX_ADMIT = 16'h1840;
  localparam logic [15:0] IDX_EGR_KIND = 16'h1841;
  localparam logic [15:0] IDX_GLOBAL = 16'h1842;
  localparam int ADDR_W = 18;
  // command register fields
  localparam int CMD_IDX_LSB = 0;
  localparam int CMD_IDX_W = 4;
  localparam int CMD_SEL_BIT = 4;
  localparam int CMD_RNW_BIT = 5;
  localparam int CMD_W = 6;
  // table geometry
  localparam int PORTS = 3;
  localparam int ENTRIES = 16;
  localparam int ENTRY_W = 18;
  localparam int VID_W = 12;
  localparam int PRIO_W = 3;
  localparam int PRIO_LSB = 12;
  localparam int UNTAG_P0_BIT = 12;
  localparam int MEMBER_P0_BIT = 13;
  localparam int PVID_W = 15;
  // reset values
  localparam logic [VID_W-1:0] PVID_RESET = 12'h001;
  localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h0;
  localparam logic [31:0] RD_DATA_RESET = 32'h0000_0000;
  localparam logic [VID_W-1:0] NULL_VID = 12'h000;
  // egress port kind, two bits per port
  localparam logic [1:0] EGR_HYBRID = 2'h3;
  localparam int GLOBAL_VLAN_DIS_BIT = 0;
  typedef enum logic [2:0] {
    VTR_IDLE = 3'b001,
    VTR_ACCESS = 3'b010,
    VTR_FINISH = 3'b100
  } vtr_state_t;
endpackage

// File: verilog/vtr_entry_mem.sv
/*
  vtr_entry_mem: sixteen vlan entries with one write port, one registered
  read port and a combinational vid match port for the frame classifier.
  Assumes one writer at a time; reads and writes are single-cycle strobes.
*/
`timescale 1ns/10ps
module vtr_entry_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [vtr_pkg::CMD_IDX_W-1:0] wr_addr,
  input wire logic [vtr_pkg::ENTRY_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [vtr_pkg::CMD_IDX_W-1:0] rd_addr,
  output logic [vtr_pkg::ENTRY_W-1:0] rd_data_q,
  input wire logic [vtr_pkg::VID_W-1:0] match_vid,
  output logic match_hit,
  output logic [vtr_pkg::ENTRY_W-1:0] match_entry
);
  logic [vtr_pkg::ENTRY_W-1:0] mem_q [vtr_pkg::ENTRIES];
  logic [vtr_pkg::ENTRY_W-1:0] mem_d [vtr_pkg::ENTRIES];
  logic [vtr_pkg::ENTRY_W-1:0] rd_data_d;
  logic [vtr_pkg::ENTRIES-1:0] hit;

  // per entry storage and vid compare; a zero vid never matches
  genvar g;
  generate
    for (g = 0; g < vtr_pkg::ENTRIES; g++) begin : g_ent
      always_comb begin
        mem_d[g] = mem_q[g];
        if (wr_en && (wr_addr == 4'(g))) begin
          mem_d[g] = wr_data;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[g] <= '0;
        end else begin
          mem_q[g] <= mem_d[g];
        end
      end
      assign hit[g] = (mem_q[g][vtr_pkg::VID_W-1:0] == match_vid) &&
                      (match_vid != vtr_pkg::NULL_VID); // R13
    end
  endgenerate

  // registered read port, holds until the next read
  always_comb begin
    rd_data_d = rd_data_q;
    if (rd_en) begin
      rd_data_d = mem_q[rd_addr];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // lowest matching entry wins if software duplicated a vid
  always_comb begin
    match_hit = 1'b0;
    match_entry = '0;
    for (int i = vtr_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        match_hit = 1'b1;
        match_entry = mem_q[i];
      end
    end
  end
endmodule

// File: verilog/vtr_classify.sv
/*
  vtr_classify: per-frame vlan decision. picks the effective vid and
  priority, the ingress drop, the egress member mask and untag mask.
  Assumes the entry match is returned combinationally for eff_vid.
*/
`timescale 1ns/10ps
module vtr_classify (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rx_valid,
  input wire logic [1:0] rx_port,
  input wire logic rx_tagged,
  input wire logic [vtr_pkg::VID_W-1:0] rx_vid,
  input wire logic rx_prio_chosen,
  input wire logic [vtr_pkg::PRIO_W-1:0] rx_prio,
  input wire logic [vtr_pkg::VID_W-1:0] port_vid,
  input wire logic [vtr_pkg::PRIO_W-1:0] port_prio,
  input wire logic vlan_disable,
  input wire logic [vtr_pkg::PORTS-1:0] admit_nonmember,
  input wire logic [2*vtr_pkg::PORTS-1:0] egress_kind,
  output logic [vtr_pkg::VID_W-1:0] eff_vid,
  input wire logic match_hit,
  input wire logic [vtr_pkg::ENTRY_W-1:0] match_entry,
  output logic fwd_valid_q,
  output logic [vtr_pkg::VID_W-1:0] fwd_vid_q,
  output logic [vtr_pkg::PRIO_W-1:0] fwd_prio_q,
  output logic fwd_drop_q,
  output logic [vtr_pkg::PORTS-1:0] fwd_member_q,
  output logic [vtr_pkg::PORTS-1:0] fwd_untag_q
);
  logic [vtr_pkg::PORTS-1:0] member;
  logic [vtr_pkg::PORTS-1:0] untag;
  logic fwd_valid_d;
  logic [vtr_pkg::VID_W-1:0] fwd_vid_d;
  logic [vtr_pkg::PRIO_W-1:0] fwd_prio_d;
  logic fwd_drop_d;
  logic [vtr_pkg::PORTS-1:0] fwd_member_d;
  logic [vtr_pkg::PORTS-1:0] fwd_untag_d;

  // default vid on untagged, null-vid or vlan-disabled frames
  assign eff_vid = (!rx_tagged || (rx_vid == vtr_pkg::NULL_VID) || vlan_disable) ?
                   port_vid : rx_vid; // R3 R4

  // member/untag pairs per port; untag only bites on hybrid egress
  genvar p;
  generate
    for (p = 0; p < vtr_pkg::PORTS; p++) begin : g_port
      assign member[p] = match_hit && match_entry[vtr_pkg::MEMBER_P0_BIT + 2*p]; // R8 R11 R12
      assign untag[p] = match_hit && match_entry[vtr_pkg::UNTAG_P0_BIT + 2*p] &&
                        (egress_kind[2*p +: 2] == vtr_pkg::EGR_HYBRID); // R10 R12
    end
  endgenerate

  // decision captured once per frame
  always_comb begin
    fwd_valid_d = rx_valid;
    fwd_vid_d = fwd_vid_q;
    fwd_prio_d = fwd_prio_q;
    fwd_drop_d = fwd_drop_q;
    fwd_member_d = fwd_member_q;
    fwd_untag_d = fwd_untag_q;
    if (rx_valid) begin
      fwd_vid_d = eff_vid;
      fwd_prio_d = rx_prio_chosen ? rx_prio : port_prio; // R5
      fwd_drop_d = !member[rx_port] && !admit_nonmember[rx_port]; // R9
      fwd_member_d = member; // R9
      fwd_untag_d = untag & member;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_valid_q <= 1'b0;
      fwd_vid_q <= '0;
      fwd_prio_q <= '0;
      fwd_drop_q <= 1'b0;
      fwd_member_q <= '0;
      fwd_untag_q <= '0;
    end else begin
      fwd_valid_q <= fwd_valid_d;
      fwd_vid_q <= fwd_vid_d;
      fwd_prio_q <= fwd_prio_d;
      fwd_drop_q <= fwd_drop_d;
      fwd_member_q <= fwd_member_d;
      fwd_untag_q <= fwd_untag_d;
    end
  end
endmodule

// File: verilog/vtr_top.sv
/*
  vtr_top: vlan table command engine with apb register access and the
  read-back data register, plus the per-frame vlan classifier.
  Assumes apb master timing per protocol; rx_port only 0..2.
*/
`timescale 1ns/10ps
module vtr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vtr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_valid,
  input wire logic [1:0] rx_port,
  input wire logic rx_tagged,
  input wire logic [vtr_pkg::VID_W-1:0] rx_vid,
  input wire logic rx_prio_chosen,
  input wire logic [vtr_pkg::PRIO_W-1:0] rx_prio,
  output logic fwd_valid_q,
  output logic [vtr_pkg::VID_W-1:0] fwd_vid_q,
  output logic [vtr_pkg::PRIO_W-1:0] fwd_prio_q,
  output logic fwd_drop_q,
  output logic [vtr_pkg::PORTS-1:0] fwd_member_q,
  output logic [vtr_pkg::PORTS-1:0] fwd_untag_q
);
  // apb decode
  logic access;
  logic [15:0] idx;
  logic hit_cmd;
  logic hit_wr;
  logic hit_rd;
  logic hit_sts;
  logic hit_adm;
  logic hit_egr;
  logic hit_glb;
  logic mapped;

  // software-visible state
  logic [vtr_pkg::CMD_W-1:0] cmd_q, cmd_d;
  logic [vtr_pkg::ENTRY_W-1:0] wr_data_q, wr_data_d;
  logic [31:0] rd_data_q, rd_data_d;
  logic [vtr_pkg::PORTS-1:0] admit_q, admit_d;
  logic [2*vtr_pkg::PORTS-1:0] egr_kind_q, egr_kind_d;
  logic vlan_dis_q, vlan_dis_d;
  logic pending_q, pending_d;
  vtr_pkg::vtr_state_t state_q, state_d;

  // default vid table, one word per port
  logic [vtr_pkg::VID_W-1:0] pvid_q [vtr_pkg::PORTS];
  logic [vtr_pkg::VID_W-1:0] pvid_d [vtr_pkg::PORTS];
  logic [vtr_pkg::PRIO_W-1:0] pprio_q [vtr_pkg::PORTS];
  logic [vtr_pkg::PRIO_W-1:0] pprio_d [vtr_pkg::PORTS];

  // command fields and table strobes
  logic [vtr_pkg::CMD_IDX_W-1:0] cmd_idx;
  logic cmd_sel_pvid;
  logic cmd_rnw;
  logic port_ok;
  logic mem_wr;
  logic mem_rd;
  logic [vtr_pkg::ENTRY_W-1:0] mem_rdata;
  logic [vtr_pkg::VID_W-1:0] eff_vid;
  logic match_hit;
  logic [vtr_pkg::ENTRY_W-1:0] match_entry;
  logic [vtr_pkg::VID_W-1:0] port_vid;
  logic [vtr_pkg::PRIO_W-1:0] port_prio;

  // zero-wait slave; unmapped or misaligned addresses get pslverr
  assign access = psel && penable;
  assign idx = paddr[17:2];
  assign hit_cmd = (idx == vtr_pkg::IDX_CMD);
  assign hit_wr = (idx == vtr_pkg::IDX_WR_DATA);
  assign hit_rd = (idx == vtr_pkg::IDX_RD_DATA);
  assign hit_sts = (idx == vtr_pkg::IDX_CMD_STATE);
  assign hit_adm = (idx == vtr_pkg::IDX_ADMIT);
  assign hit_egr = (idx == vtr_pkg::IDX_EGR_KIND);
  assign hit_glb = (idx == vtr_pkg::IDX_GLOBAL);
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (hit_cmd || hit_wr || hit_rd || hit_sts || hit_adm || hit_egr || hit_glb);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // read mux; reads change no state
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && mapped && !pwrite) begin
      if (hit_cmd) begin
        prdata = {26'h000_0000, cmd_q};
      end else if (hit_wr) begin
        prdata = {14'h0000, wr_data_q};
      end else if (hit_rd) begin
        prdata = rd_data_q; // R1 R15
      end else if (hit_sts) begin
        prdata = {31'h0000_0000, pending_q}; // R14
      end else if (hit_adm) begin
        prdata = {29'h0000_0000, admit_q};
      end else if (hit_egr) begin
        prdata = {26'h000_0000, egr_kind_q};
      end else begin
        prdata = {31'h0000_0000, vlan_dis_q};
      end
    end
  end

  assign cmd_idx = cmd_q[vtr_pkg::CMD_IDX_LSB +: vtr_pkg::CMD_IDX_W];
  assign cmd_sel_pvid = cmd_q[vtr_pkg::CMD_SEL_BIT];
  assign cmd_rnw = cmd_q[vtr_pkg::CMD_RNW_BIT];
  // port indices above 2 touch nothing and read back zero
  assign port_ok = (cmd_idx < 4'(vtr_pkg::PORTS));
  assign mem_wr = (state_q == vtr_pkg::VTR_ACCESS) && !cmd_sel_pvid && !cmd_rnw;
  assign mem_rd = (state_q == vtr_pkg::VTR_ACCESS) && !cmd_sel_pvid && cmd_rnw;

  // plain config registers and command capture; command ignored while busy
  always_comb begin
    cmd_d = cmd_q;
    wr_data_d = wr_data_q;
    admit_d = admit_q;
    egr_kind_d = egr_kind_q;
    vlan_dis_d = vlan_dis_q;
    if (access && pwrite && mapped) begin
      if (hit_cmd && !pending_q) begin
        cmd_d = pwdata[vtr_pkg::CMD_W-1:0];
      end
      if (hit_wr) begin
        wr_data_d = pwdata[vtr_pkg::ENTRY_W-1:0];
      end
      if (hit_adm) begin
        admit_d = pwdata[vtr_pkg::PORTS-1:0];
      end
      if (hit_egr) begin
        egr_kind_d = pwdata[2*vtr_pkg::PORTS-1:0];
      end
      if (hit_glb) begin
        vlan_dis_d = pwdata[vtr_pkg::GLOBAL_VLAN_DIS_BIT];
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= '0;
      wr_data_q <= '0;
      admit_q <= '0;
      egr_kind_q <= '0;
      vlan_dis_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      wr_data_q <= wr_data_d;
      admit_q <= admit_d;
      egr_kind_q <= egr_kind_d;
      vlan_dis_q <= vlan_dis_d;
    end
  end

  // command engine: accept, access table, capture result
  always_comb begin
    state_d = state_q;
    pending_d = pending_q;
    rd_data_d = rd_data_q;
    case (state_q)
      vtr_pkg::VTR_IDLE: begin
        if (access && pwrite && hit_cmd && mapped) begin
          state_d = vtr_pkg::VTR_ACCESS;
          pending_d = 1'b1; // R14
        end
      end
      vtr_pkg::VTR_ACCESS: begin
        state_d = vtr_pkg::VTR_FINISH;
      end
      vtr_pkg::VTR_FINISH: begin
        state_d = vtr_pkg::VTR_IDLE;
        pending_d = 1'b0; // R14
        if (cmd_rnw && cmd_sel_pvid) begin
          rd_data_d = port_ok ? {17'h0_0000, pprio_q[cmd_idx[1:0]], pvid_q[cmd_idx[1:0]]} :
                      32'h0000_0000; // R2
        end else if (cmd_rnw) begin
          rd_data_d = {14'h0000, mem_rdata}; // R8 R12 R13
        end
      end
      default: begin
        state_d = vtr_pkg::VTR_IDLE;
        pending_d = 1'b0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= vtr_pkg::VTR_IDLE;
      pending_q <= 1'b0;
      rd_data_q <= vtr_pkg::RD_DATA_RESET;
    end else begin
      state_q <= state_d;
      pending_q <= pending_d;
      rd_data_q <= rd_data_d; // R15
    end
  end

  // default vid table; software should avoid vid 0 and fff here
  genvar p;
  generate
    for (p = 0; p < vtr_pkg::PORTS; p++) begin : g_pvid
      always_comb begin
        pvid_d[p] = pvid_q[p];
        pprio_d[p] = pprio_q[p];
        if ((state_q == vtr_pkg::VTR_ACCESS) && cmd_sel_pvid && !cmd_rnw &&
            (cmd_idx == 4'(p))) begin
          pvid_d[p] = wr_data_q[vtr_pkg::VID_W-1:0];
          pprio_d[p] = wr_data_q[vtr_pkg::PRIO_LSB +: vtr_pkg::PRIO_W];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pvid_q[p] <= vtr_pkg::PVID_RESET; // R6
          pprio_q[p] <= vtr_pkg::PRIO_RESET; // R6
        end else begin
          pvid_q[p] <= pvid_d[p];
          pprio_q[p] <= pprio_d[p];
        end
      end
    end
  endgenerate

  // rx_port 3 falls back to port 0 defaults
  assign port_vid = (rx_port < 2'(vtr_pkg::PORTS)) ? pvid_q[rx_port] : pvid_q[0];
  assign port_prio = (rx_port < 2'(vtr_pkg::PORTS)) ? pprio_q[rx_port] : pprio_q[0];

  vtr_entry_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(mem_wr),
    .wr_addr(cmd_idx),
    .wr_data(wr_data_q),
    .rd_en(mem_rd),
    .rd_addr(cmd_idx),
    .rd_data_q(mem_rdata),
    .match_vid(eff_vid),
    .match_hit(match_hit),
    .match_entry(match_entry)
  );

  vtr_classify u_cls (
    .pclk(pclk),
    .presetn(presetn),
    .rx_valid(rx_valid),
    .rx_port(rx_port),
    .rx_tagged(rx_tagged),
    .rx_vid(rx_vid),
    .rx_prio_chosen(rx_prio_chosen),
    .rx_prio(rx_prio),
    .port_vid(port_vid),
    .port_prio(port_prio),
    .vlan_disable(vlan_dis_q),
    .admit_nonmember(admit_q),
    .egress_kind(egr_kind_q),
    .eff_vid(eff_vid),
    .match_hit(match_hit),
    .match_entry(match_entry),
    .fwd_valid_q(fwd_valid_q),
    .fwd_vid_q(fwd_vid_q),
    .fwd_prio_q(fwd_prio_q),
    .fwd_drop_q(fwd_drop_q),
    .fwd_member_q(fwd_member_q),
    .fwd_untag_q(fwd_untag_q)
  );
endmodule

// File: verification/vtr_top_asserts.sv
/*
  vtr_top_chk: port-level checks of the vlan table block, apb side and
  frame side. Assumes it is bound to vtr_top and sees only its ports.
*/
`timescale 1ns/10ps
module vtr_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [vtr_pkg::ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_valid,
  input wire logic [1:0] rx_port,
  input wire logic rx_prio_chosen,
  input wire logic [vtr_pkg::PRIO_W-1:0] rx_prio,
  input wire logic fwd_valid_q,
  input wire logic [vtr_pkg::VID_W-1:0] fwd_vid_q,
  input wire logic [vtr_pkg::PRIO_W-1:0] fwd_prio_q,
  input wire logic fwd_drop_q,
  input wire logic [vtr_pkg::PORTS-1:0] fwd_member_q,
  input wire logic [vtr_pkg::PORTS-1:0] fwd_untag_q
);
  // single domain, so one clocking and one disable for all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("apb access not answered at once");
  a_misalign_err: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_err_access: assert property (!(psel && penable) |-> !pslverr)
    else $error("error flag outside access phase");
  a_fwd_answer: assert property (rx_valid |=> fwd_valid_q)
    else $error("frame result missing");
  a_fwd_cause: assert property (fwd_valid_q |-> $past(rx_valid))
    else $error("frame result without a frame");
  a_fwd_hold: assert property (!rx_valid |=>
      $stable({fwd_vid_q, fwd_prio_q, fwd_drop_q, fwd_member_q, fwd_untag_q}))
    else $error("frame result changed without a frame");
  a_prio_pass: assert property (rx_valid && rx_prio_chosen |=> fwd_prio_q == $past(rx_prio))
    else $error("chosen priority not kept");
  a_untag_member: assert property (fwd_valid_q |-> (fwd_untag_q & ~fwd_member_q) == '0)
    else $error("untag on a non-member port");
  a_member_admit: assert property (fwd_valid_q && fwd_member_q[$past(rx_port)] |-> !fwd_drop_q)
    else $error("member frame dropped");
endmodule

bind vtr_top vtr_top_chk u_vtr_top_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .rx_valid, .rx_port, .rx_prio_chosen, .rx_prio, .fwd_valid_q, .fwd_vid_q,
  .fwd_prio_q, .fwd_drop_q, .fwd_member_q, .fwd_untag_q);

// File: verification/testbench.sv
/*
  testbench: drives vtr_top over apb and its frame port and compares with
  a table model kept here. Assumes one 100 MHz clock and zero-wait apb.
*/
`timescale 1ns/10ps
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, rx_valid, rx_tagged, rx_prio_chosen;
  logic pready, pslverr, fwd_valid_q, fwd_drop_q, vdis;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, last;
  logic [1:0] rx_port;
  logic [11:0] rx_vid, fwd_vid_q;
  logic [2:0] rx_prio, fwd_prio_q, fwd_member_q, fwd_untag_q, adm;
  logic [5:0] egr;
  logic [17:0] ent [16];
  logic [11:0] pv [3];
  logic [2:0] pp [3];
  int n_errors = 0;
  int checked = 0;
  bit keep = 1'b0;
  bit chained = 1'b0;

  always #5 pclk = ~pclk;

  vtr_top u_vtr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .rx_port, .rx_tagged, .rx_vid, .rx_prio_chosen, .rx_prio,
    .fwd_valid_q, .fwd_vid_q, .fwd_prio_q, .fwd_drop_q, .fwd_member_q, .fwd_untag_q);

  task automatic stop_test;
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; a clock passes first so psel never toggles twice in a step,
  // except behind a transfer that kept psel high for a back-to-back setup
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    if (!chained) @(posedge pclk);
    chained = keep;
    keep = 1'b0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_errors++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    if (!chained) psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] i, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {i, 2'b00}, d, r, e);
  endtask

  task automatic rdc(input logic [15:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, {i, 2'b00}, '0, r, e);
    check(r, x);
    check({31'h0, e}, '0);
  endtask

  // table command, then bounded poll until the pending flag drops
  task automatic tcmd(input logic [3:0] idx, input logic sel, input logic rnw);
    logic [31:0] r;
    logic e;
    int k;
    wr(vtr_pkg::IDX_CMD, {26'h0, rnw, sel, idx});
    for (k = 0; k < 8; k++) begin
      apb(1'b0, {vtr_pkg::IDX_CMD_STATE, 2'b00}, '0, r, e);
      if (r[0] === 1'b0) break;
    end
    check({31'h0, r[0]}, '0);
    if (k == 8) stop_test();
  endtask

  initial begin
    int p, n, k;
    logic [31:0] r, x;
    logic e, tg, ch, dr;
    logic [11:0] v, ev;
    logic [2:0] mem, ut, hyb, pr;
    logic [1:0] port;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    rx_valid = 1'b0;
    rx_port = '0;
    rx_tagged = 1'b0;
    rx_vid = '0;
    rx_prio_chosen = 1'b0;
    rx_prio = '0;
    vdis = 1'b0;
    void'($urandom(39578));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(vtr_pkg::IDX_RD_DATA, '0);
    // reset defaults per port, then new defaults; write commands leave read data alone
    for (p = 0; p < 3; p++) begin
      tcmd(p[3:0], 1'b1, 1'b1);
      rdc(vtr_pkg::IDX_RD_DATA, 32'h0000_0001);
      pv[p] = 12'(1 + $urandom % 5);
      pp[p] = 3'($urandom);
      wr(vtr_pkg::IDX_WR_DATA, {17'h0, pp[p], pv[p]});
      tcmd(p[3:0], 1'b1, 1'b0);
      rdc(vtr_pkg::IDX_RD_DATA, 32'h0000_0001);
      tcmd(p[3:0], 1'b1, 1'b1);
      rdc(vtr_pkg::IDX_RD_DATA, {17'h0, pp[p], pv[p]});
    end
    // status read right behind a command write sees the pending flag still up
    keep = 1'b1;
    wr(vtr_pkg::IDX_CMD, 32'h0000_0030);
    apb(1'b0, {vtr_pkg::IDX_CMD_STATE, 2'b00}, '0, r, e);
    check(r, 32'h0000_0001);
    rdc(vtr_pkg::IDX_RD_DATA, {17'h0, pp[0], pv[0]});
    tcmd(4'h3, 1'b1, 1'b1);
    rdc(vtr_pkg::IDX_RD_DATA, '0);
    // small vid range so frames hit entries, duplicates and disabled ones
    for (p = 0; p < 16; p++) begin
      ent[p] = {6'($urandom), 12'($urandom % 6)};
      wr(vtr_pkg::IDX_WR_DATA, {14'h0, ent[p]});
      tcmd(p[3:0], 1'b0, 1'b0);
      tcmd(p[3:0], 1'b0, 1'b1);
      rdc(vtr_pkg::IDX_RD_DATA, {14'h0, ent[p]});
    end
    last = {14'h0, ent[15]};
    wr(vtr_pkg::IDX_RD_DATA, 32'hffff_ffff);
    rdc(vtr_pkg::IDX_RD_DATA, last);
    apb(1'b0, {vtr_pkg::IDX_RD_DATA, 2'b01}, '0, r, e);
    check({31'h0, e}, 32'h0000_0001);
    apb(1'b0, '0, '0, r, e);
    check({31'h0, e}, 32'h0000_0001);
    adm = 3'($urandom);
    egr = 6'($urandom);
    hyb = {egr[5:4] == 2'h3, egr[3:2] == 2'h3, egr[1:0] == 2'h3};
    wr(vtr_pkg::IDX_ADMIT, {29'h0, adm});
    wr(vtr_pkg::IDX_EGR_KIND, {26'h0, egr});
    wr(vtr_pkg::IDX_GLOBAL, '0);
    // random frames; second half with vlan awareness switched off
    for (n = 0; n < 80; n++) begin
      if (n == 40) begin
        vdis = 1'b1;
        wr(vtr_pkg::IDX_GLOBAL, 32'h0000_0001);
      end
      port = 2'($urandom % 3);
      tg = 1'($urandom);
      v = 12'($urandom % 7);
      ch = 1'($urandom);
      pr = 3'($urandom);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_port <= port;
      rx_tagged <= tg;
      rx_vid <= v;
      rx_prio_chosen <= ch;
      rx_prio <= pr;
      @(posedge pclk);
      rx_valid <= 1'b0;
      #1;
      ev = (!tg || v == 12'h000 || vdis) ? pv[port] : v;
      mem = '0;
      ut = '0;
      for (k = 15; k >= 0; k--) begin
        if (ent[k][11:0] == ev) begin
          mem = {ent[k][17], ent[k][15], ent[k][13]};
          ut = {ent[k][16], ent[k][14], ent[k][12]};
        end
      end
      dr = !mem[port] && !adm[port];
      x = {10'h0, ut & mem & hyb, mem, dr, ch ? pr : pp[port], ev};
      r = {10'h0, fwd_untag_q, fwd_member_q, fwd_drop_q, fwd_prio_q, fwd_vid_q};
      check({31'h0, fwd_valid_q}, 32'h0000_0001);
      check(r, x);
    end
    stop_test();
  end
endmodule
